// *** common/tac_pkg.sv ***
/*
 * Shared constants and types of the touch ADC serial conversion control.
 * Assumes a 50 MHz system clock and a host-driven shift clock.
 */
package tac_pkg;
    // ==========================================================
    // control byte layout (seven bits after the start bit)
    localparam int          CTRL_W      = 7;
    localparam int          CH_HI       = 6;
    localparam int          CH_LO       = 4;
    localparam int          MODE_BIT    = 3;
    localparam int          SER_BIT     = 2;
    localparam int          PD1_BIT     = 1;
    localparam int          PD0_BIT     = 0;
    localparam logic [2:0]  CTRL_LAST   = 3'h6;
    localparam logic [2:0]  ACQ_START   = 3'h3;
    // ==========================================================
    // result format
    localparam int          RES_W       = 12;
    localparam logic [3:0]  LAST12      = 4'hB;
    localparam logic [3:0]  LAST8       = 4'h7;
    // ==========================================================
    // reset values
    localparam logic        REF_RST     = 1'h0;
    localparam logic        PWRUP_RST   = 1'h1;
    // ==========================================================
    // timing
    localparam int          CONV_MAX_NS = 1600000;
    localparam int          SYS_CLK_NS  = 20;
    localparam int          CONV_MAX_CYC = CONV_MAX_NS / SYS_CLK_NS;
    localparam int          DROOP_W     = 17;
    // ==========================================================
    // states
    typedef enum logic {PS_HUNT = 1'h0, PS_CTRL = 1'h1} tac_parse_t;
    typedef enum logic [1:0] {
        CV_IDLE  = 2'h0,
        CV_BUSY  = 2'h1,
        CV_SHIFT = 2'h3
    } tac_conv_t;
endpackage : tac_pkg

// *** common/tac_xing_if.sv ***
/*
 * Carrier between the link-side control and the clock-crossing bridge.
 * Assumes toggles and levels are synchronised by the receiving side.
 */
`timescale 1ns/1ns
`default_nettype none
interface tac_xing_if;
    logic                          sampleReqTgl;
    logic                          sampleAckTgl;
    logic [tac_pkg::RES_W-1:0]     sampleWord;
    logic                          convActive;
    logic                          refOn;
    logic                          adcPowered;
    modport link (output sampleReqTgl, convActive, refOn, adcPowered,
                  input  sampleAckTgl, sampleWord);
    modport bridge (input  sampleReqTgl, convActive, refOn, adcPowered,
                    output sampleAckTgl, sampleWord);
endinterface : tac_xing_if
`default_nettype wire

// *** logic/tac_sample_bridge.sv ***
/*
 * Clock crossing: sample request/ack handshake, status levels, droop watch.
 * Assumes sampleWord is read only after the ack toggle has been synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
module tac_sample_bridge #(
    parameter int CONV_MAX_CYC = tac_pkg::CONV_MAX_CYC
) (
    // clocks and reset
    input  wire logic                      sys_clk,
    input  wire logic                      shift_clock,
    input  wire logic                      nrst,
    // analog result
    input  wire logic [tac_pkg::RES_W-1:0] adcCode,
    // system status
    output var  logic                      sysAdcPowered,
    output var  logic                      sysRefPowered,
    output var  logic                      droopWarn,
    // link side
    tac_xing_if.bridge                     x
);
    import tac_pkg::*;
    // ==========================================================
    // system domain
    logic                  req1_q, req2_q, req3_q;
    logic                  ack_q, ack_d;
    logic [RES_W-1:0]      word_q, word_d;
    logic [2:0]            st1_q, st2_q;
    logic [DROOP_W-1:0]    cnt_q, cnt_d;
    logic                  warn_d;
    always_comb begin
        ack_d  = ack_q;
        word_d = word_q;
        if (req2_q != req3_q) begin
            ack_d  = ~ack_q;
            word_d = adcCode;
        end
        cnt_d  = st2_q[2] ? cnt_q + DROOP_W'(1) : '0;
        warn_d = st2_q[2] && (cnt_q >= DROOP_W'(CONV_MAX_CYC));
        if (warn_d) begin
            cnt_d = cnt_q;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            req1_q    <= 1'h0;
            req2_q    <= 1'h0;
            req3_q    <= 1'h0;
            ack_q     <= 1'h0;
            word_q    <= '0;
            st1_q     <= 3'h0;
            st2_q     <= 3'h0;
            cnt_q     <= '0;
            droopWarn <= 1'h0;
        end else begin
            req1_q    <= x.sampleReqTgl;
            req2_q    <= req1_q;
            req3_q    <= req2_q;
            ack_q     <= ack_d;
            word_q    <= word_d;
            st1_q     <= {x.convActive, x.refOn, x.adcPowered};
            st2_q     <= st1_q;
            cnt_q     <= cnt_d;
            droopWarn <= warn_d;
        end
    end
    assign sysAdcPowered = st2_q[0];
    assign sysRefPowered = st2_q[1];
    assign x.sampleWord  = word_q;
    // ==========================================================
    // link domain
    logic ackL1_q, ackL2_q;
    always_ff @(posedge shift_clock or negedge nrst) begin
        if (!nrst) begin
            ackL1_q <= 1'h0;
            ackL2_q <= 1'h0;
        end else begin
            ackL1_q <= ack_q;
            ackL2_q <= ackL1_q;
        end
    end
    assign x.sampleAckTgl = ackL2_q;
    // ==========================================================
    // checks
    property p_word_capture;
        @(posedge sys_clk) disable iff (!nrst)
        (req2_q != req3_q) |=> (word_q == $past(adcCode)) && (ack_q != $past(ack_q));
    endproperty
    a_word_capture: assert property (p_word_capture) else $error("sample not captured");
endmodule : tac_sample_bridge
`default_nettype wire

// *** logic/tac_serial_ctrl.sv ***
/*
 * Serial conversion sequencing and power control of a touch screen ADC.
 * Assumes a host serial master on shift_clock, csN, serialIn and an
 * analog code presented on adcCode in the sys_clk domain.
 */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - next control byte may shift in during result output; 16 clocks each
// - converter stays fully powered throughout a conversion
// - 15-clock unbroken sequencing per conversion is supported
// - results are unsigned straight binary
// - 8-bit mode ends four clocks sooner with four fewer result bits
// - power-down select 1 keeps full power, 0 auto power-down
// - single-ended mode: panel drivers on only during acquisition
// - differential mode: panel drivers on during acquisition and conversion
// - chip select high abandons the conversion at once; powers down unless still in the power-up state
// - chip select high leaves the reference state untouched
// - after power-up stay powered until a byte with power-down select 0
// - serial input sampled on each rising shift clock edge
// - serial output changes after each falling shift clock edge
// - busy changes on falling shift clock edges and clears at once when chip select goes high
// - serial output driven only while chip select is low
// - busy driven only while chip select is low
// - control byte starts with a 1; input ignored until then
// - resolution select low gives 12 bits, high gives 8 bits
// - reference state from a control byte takes effect as busy rises
// - auto power-down after each conversion, instant power-up at next
module tac_serial_ctrl #(
    parameter int CONV_MAX_CYC = tac_pkg::CONV_MAX_CYC
) (
    // system clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    // serial link
    input  wire logic                      shift_clock,
    input  wire logic                      csN,
    input  wire logic                      serialIn,
    output var  logic                      serialOut,
    output var  logic                      serialOutOe,
    output var  logic                      busyOut,
    output var  logic                      busyOe,
    // analog side
    input  wire logic [tac_pkg::RES_W-1:0] adcCode,
    output var  logic [2:0]                muxChannel,
    output var  logic                      panelDriveOn,
    output var  logic                      adcPowered,
    output var  logic                      refPowered,
    // system status
    output var  logic                      sysAdcPowered,
    output var  logic                      sysRefPowered,
    output var  logic                      droopWarn
);
    import tac_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [3:0] lastBitIdx(input logic mode8);
        return mode8 ? LAST8 : LAST12;
    endfunction : lastBitIdx

    function automatic logic [RES_W-1:0] alignCode(input logic mode8,
                                                   input logic [RES_W-1:0] code);
        return mode8 ? {code[RES_W-1:4], 4'h0} : code;
    endfunction : alignCode

    // chip select high clears the parser and conversion logic at once
    logic linkRst;
    assign linkRst = ~nrst | csN;

    tac_xing_if xif ();

    // ==========================================================
    // control byte parser, rising edge
    tac_parse_t        psState_q, psState_d;
    logic [2:0]        bitCnt_q, bitCnt_d;
    logic [CTRL_W-1:0] ctrlSh_q, ctrlSh_d;
    logic              byteDone_q, byteDone_d;
    logic              reqTgl_q, reqTgl_d;
    logic              acquiring;

    always_comb begin
        psState_d  = psState_q;
        bitCnt_d   = bitCnt_q;
        ctrlSh_d   = ctrlSh_q;
        byteDone_d = 1'h0;
        reqTgl_d   = reqTgl_q;
        case (psState_q)
            PS_HUNT: begin
                if (serialIn) begin
                    psState_d = PS_CTRL;
                    bitCnt_d  = 3'h0;
                end
            end
            PS_CTRL: begin
                ctrlSh_d = {ctrlSh_q[CTRL_W-2:0], serialIn};
                bitCnt_d = bitCnt_q + 3'h1;
                if (bitCnt_q == ACQ_START) begin
                    reqTgl_d = ~reqTgl_q;
                end
                if (bitCnt_q == CTRL_LAST) begin
                    byteDone_d = 1'h1;
                    psState_d  = PS_HUNT;
                end
            end
            default: psState_d = PS_HUNT;
        endcase
    end

    always_ff @(posedge shift_clock or posedge linkRst) begin
        if (linkRst) begin
            psState_q  <= PS_HUNT;
            bitCnt_q   <= 3'h0;
            ctrlSh_q   <= '0;
            byteDone_q <= 1'h0;
        end else begin
            psState_q  <= psState_d;
            bitCnt_q   <= bitCnt_d;
            ctrlSh_q   <= ctrlSh_d;
            byteDone_q <= byteDone_d;
        end
    end

    // request toggle survives chip select so it stays paired with the ack toggle
    always_ff @(posedge shift_clock or negedge nrst) begin
        if (!nrst) begin
            reqTgl_q <= 1'h0;
        end else begin
            reqTgl_q <= reqTgl_d;
        end
    end

    assign acquiring = ((psState_q == PS_CTRL) && (bitCnt_q > ACQ_START)) || byteDone_q;

    // ==========================================================
    // conversion and result output, falling edge
    tac_conv_t         cvState_q, cvState_d;
    logic              busy_q, busy_d;
    logic [RES_W-1:0]  outWord_q, outWord_d;
    logic [3:0]        bitsLeft_q, bitsLeft_d;
    logic              sout_q, sout_d;
    logic              mode8_q, mode8_d;
    logic              ser_q, ser_d;
    logic [2:0]        chan_q, chan_d;
    logic              fullPower_q, fullPower_d;
    logic [RES_W-1:0]  loadWord;
    logic              convActive;

    always_comb begin
        cvState_d   = cvState_q;
        busy_d      = busy_q;
        outWord_d   = outWord_q;
        bitsLeft_d  = bitsLeft_q;
        sout_d      = sout_q;
        mode8_d     = mode8_q;
        ser_d       = ser_q;
        chan_d      = chan_q;
        fullPower_d = fullPower_q;
        loadWord    = '0;
        if (xif.sampleAckTgl == reqTgl_q) begin
            loadWord = alignCode(mode8_q, xif.sampleWord);
        end
        if (byteDone_q) begin
            // a new byte preempts any result still going out
            cvState_d   = CV_BUSY;
            busy_d      = 1'h1;
            sout_d      = 1'h0;
            mode8_d     = ctrlSh_q[MODE_BIT];
            ser_d       = ctrlSh_q[SER_BIT];
            chan_d      = ctrlSh_q[CH_HI:CH_LO];
            fullPower_d = ctrlSh_q[PD0_BIT];
        end else begin
            case (cvState_q)
                CV_IDLE: begin
                    sout_d = 1'h0;
                end
                CV_BUSY: begin
                    busy_d     = 1'h0;
                    cvState_d  = CV_SHIFT;
                    sout_d     = loadWord[RES_W-1];
                    outWord_d  = {loadWord[RES_W-2:0], 1'h0};
                    bitsLeft_d = lastBitIdx(mode8_q);
                end
                CV_SHIFT: begin
                    if (bitsLeft_q == 4'h0) begin
                        cvState_d = CV_IDLE;
                        sout_d    = 1'h0;
                    end else begin
                        sout_d     = outWord_q[RES_W-1];
                        outWord_d  = {outWord_q[RES_W-2:0], 1'h0};
                        bitsLeft_d = bitsLeft_q - 4'h1;
                    end
                end
                default: cvState_d = CV_IDLE;
            endcase
        end
    end

    always_ff @(negedge shift_clock or posedge linkRst) begin
        if (linkRst) begin
            cvState_q   <= CV_IDLE;
            busy_q      <= 1'h0;
            outWord_q   <= '0;
            bitsLeft_q  <= 4'h0;
            sout_q      <= 1'h0;
            mode8_q     <= 1'h0;
            ser_q       <= 1'h0;
            chan_q      <= 3'h0;
            fullPower_q <= 1'h0;
        end else begin
            cvState_q   <= cvState_d;
            busy_q      <= busy_d;
            outWord_q   <= outWord_d;
            bitsLeft_q  <= bitsLeft_d;
            sout_q      <= sout_d;
            mode8_q     <= mode8_d;
            ser_q       <= ser_d;
            chan_q      <= chan_d;
            fullPower_q <= fullPower_d;
        end
    end

    // ==========================================================
    // persistent power state, untouched by chip select, reset only by system reset
    logic refOn_q, refOn_d;
    logic pwrUp_q, pwrUp_d;

    always_comb begin
        refOn_d = refOn_q;
        pwrUp_d = pwrUp_q;
        if (byteDone_q) begin
            refOn_d = ctrlSh_q[PD1_BIT];
            pwrUp_d = pwrUp_q & ctrlSh_q[PD0_BIT];
        end
    end

    always_ff @(negedge shift_clock or negedge nrst) begin
        if (!nrst) begin
            refOn_q <= REF_RST;
            pwrUp_q <= PWRUP_RST;
        end else begin
            refOn_q <= refOn_d;
            pwrUp_q <= pwrUp_d;
        end
    end

    // ==========================================================
    // outputs
    assign convActive   = (cvState_q != CV_IDLE) || acquiring;
    assign adcPowered   = pwrUp_q | fullPower_q | convActive;
    assign refPowered   = refOn_q;
    assign panelDriveOn = acquiring | ((cvState_q != CV_IDLE) & ~ser_q);
    assign muxChannel   = chan_q;
    assign serialOut    = sout_q;
    assign busyOut      = busy_q;
    assign serialOutOe  = ~csN;
    assign busyOe       = ~csN;

    assign xif.sampleReqTgl = reqTgl_q;
    assign xif.convActive   = convActive;
    assign xif.refOn        = refOn_q;
    assign xif.adcPowered   = adcPowered;

    tac_sample_bridge #(
        .CONV_MAX_CYC (CONV_MAX_CYC)
    ) u_bridge (
        .sys_clk       (sys_clk),
        .shift_clock   (shift_clock),
        .nrst          (nrst),
        .adcCode       (adcCode),
        .sysAdcPowered (sysAdcPowered),
        .sysRefPowered (sysRefPowered),
        .droopWarn     (droopWarn),
        .x             (xif)
    );

    // ==========================================================
    // checks
    sequence s_busy_pulse;
        busy_q ##1 (!busy_q && cvState_q == CV_SHIFT);
    endsequence

    property p_busy_one;
        @(negedge shift_clock) disable iff (linkRst)
        $rose(busy_q) |-> s_busy_pulse;
    endproperty
    a_busy_one: assert property (p_busy_one) else $error("busy not one clock");

    property p_start_hunt;
        @(posedge shift_clock) disable iff (linkRst)
        (psState_q == PS_HUNT && !serialIn) |=> psState_q == PS_HUNT;
    endproperty
    a_start_hunt: assert property (p_start_hunt) else $error("left hunt without start");

    // cycles spent shifting the result, for the length checks
    logic [3:0] shCnt_q, shCnt_d;

    always_comb begin
        shCnt_d = (cvState_q == CV_SHIFT) ? shCnt_q + 4'h1 : 4'h0;
    end

    always_ff @(negedge shift_clock or posedge linkRst) begin
        if (linkRst) begin
            shCnt_q <= 4'h0;
        end else begin
            shCnt_q <= shCnt_d;
        end
    end

    property p_len12;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q == CV_SHIFT && bitsLeft_q == 4'h0 && !mode8_q) |-> shCnt_q == 4'hB;
    endproperty
    a_len12: assert property (p_len12) else $error("12-bit length wrong");

    property p_len8;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q == CV_SHIFT && bitsLeft_q == 4'h0 && mode8_q) |-> shCnt_q == 4'h7;
    endproperty
    a_len8: assert property (p_len8) else $error("8-bit length wrong");

    property p_ref_latch;
        @(negedge shift_clock) disable iff (!nrst)
        byteDone_q |=> refOn_q == $past(ctrlSh_q[PD1_BIT]);
    endproperty
    a_ref_latch: assert property (p_ref_latch) else $error("reference not latched");

    property p_conv_power;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q != CV_IDLE) |-> adcPowered;
    endproperty
    a_conv_power: assert property (p_conv_power) else $error("unpowered in conversion");

    property p_auto_down;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q == CV_SHIFT && bitsLeft_q == 4'h0 && !fullPower_q && !pwrUp_q
            && !byteDone_q) |=> (!acquiring -> !adcPowered);
    endproperty
    a_auto_down: assert property (p_auto_down) else $error("no auto power-down");

    property p_single_ended;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q == CV_SHIFT && ser_q && !acquiring) |-> !panelDriveOn;
    endproperty
    a_single_ended: assert property (p_single_ended) else $error("drivers on in conversion");

    property p_differential;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q != CV_IDLE && !ser_q) |-> panelDriveOn;
    endproperty
    a_differential: assert property (p_differential) else $error("drivers off in conversion");

    property p_pipeline;
        @(negedge shift_clock) disable iff (linkRst)
        (cvState_q == CV_SHIFT && byteDone_q) |=> (busy_q && cvState_q == CV_BUSY);
    endproperty
    a_pipeline: assert property (p_pipeline) else $error("overlapped byte lost");

    property p_oe_off;
        @(posedge sys_clk) disable iff (!nrst)
        csN |-> (!serialOutOe && !busyOe && !busy_q);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
endmodule : tac_serial_ctrl
`default_nettype wire

// *** verification/tac_host_model.sv ***
/* Host serial master model: chip select, shift clock, serial input.
   Assumes the bench calls select and stream; the clock stands still between. */
`timescale 1ns/1ns
`default_nettype none
module tac_host_model (
    // system clock
    input  wire logic sys_clk,
    // serial link
    output var  logic shift_clock,
    output var  logic csN,
    output var  logic serialIn,
    input  wire logic serialOut,
    input  wire logic busyOut
);
    initial begin
        shift_clock = 1'h1;
        csN         = 1'h0;
        serialIn    = 1'h0;
    end
    // ==========================================================
    // chip select, then setup before the first clock
    task automatic select(input logic v);
        @(negedge sys_clk) csN = v;
        #150;
    endtask : select
    // ==========================================================
    // n clocks of 125 ns, din and dout MSB first; same rate in 8-bit mode
    task automatic stream(input logic [63:0] din, input int n,
                          output logic [63:0] dout, output logic [63:0] bsy);
        dout = '0;
        bsy  = '0;
        #37;
        for (int i = 0; i < n; i++) begin
            serialIn = din[63-i];
            #62 shift_clock = 1'h1;
            dout[63-i] = serialOut;
            bsy[63-i]  = busyOut;
            #63 shift_clock = 1'h0;
        end
        serialIn = ~serialIn;
    endtask : stream
endmodule : tac_host_model
`default_nettype wire

// *** verification/test_touch_adc_serial_conversion_control.sv ***
/* Self-checking bench of the serial conversion control.
   Assumes the host model drives the link; sys_clk is 50 MHz. */
`timescale 1ns/1ns
`default_nettype none
module test_touch_adc_serial_conversion_control;
    import tac_pkg::*;
    logic             sys_clk, nrst, shift_clock, csN, serialIn, serialOut;
    logic             serialOutOe, busyOut, busyOe, panelDriveOn, adcPowered;
    logic             refPowered, sysAdcPowered, sysRefPowered, droopWarn;
    logic [RES_W-1:0] adcCode;
    logic [2:0]       muxChannel;
    logic [63:0]      dout, bsy, pdv;
    int               errors = 0;
    int               tests_run = 0;

    tac_serial_ctrl #(.CONV_MAX_CYC(200)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .shift_clock(shift_clock), .csN(csN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe),
        .busyOut(busyOut), .busyOe(busyOe), .adcCode(adcCode),
        .muxChannel(muxChannel), .panelDriveOn(panelDriveOn),
        .adcPowered(adcPowered), .refPowered(refPowered),
        .sysAdcPowered(sysAdcPowered), .sysRefPowered(sysRefPowered),
        .droopWarn(droopWarn));
    tac_host_model host (.sys_clk(sys_clk), .shift_clock(shift_clock), .csN(csN),
        .serialIn(serialIn), .serialOut(serialOut), .busyOut(busyOut));

    initial sys_clk = 1'h0;
    always #10 sys_clk = ~sys_clk;
    // panel driver level seen at each rising shift clock
    always @(posedge shift_clock) pdv <= {pdv[62:0], panelDriveOn};

    // ==========================================================
    // compare and verdict
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chkv(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chkv
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    function automatic logic [7:0] mk(input logic [2:0] ch, input logic md,
                                      input logic sr, input logic p1, input logic p0);
        return {1'h1, ch, md, sr, p1, p0};
    endfunction : mk

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk1(adcPowered, 1'h1);
        chk1(refPowered, 1'h0);
        chk1(serialOutOe, 1'h0);
        chk1(busyOe, 1'h0);
    endtask : t_reset
    // leading zeros, 12-bit then 8-bit, 16 clocks apart
    task automatic t_overlap16();
        @(negedge sys_clk) adcCode = 12'hA5C;
        host.select(1'h0);
        host.stream({2'h0, mk(3'h5, 1'h0, 1'h1, 1'h1, 1'h1), 8'h0,
                     mk(3'h2, 1'h1, 1'h1, 1'h1, 1'h1), 38'h0}, 38, dout, bsy);
        chk1(bsy[54], 1'h0);
        chk1(bsy[53], 1'h1);
        chk1(bsy[52], 1'h0);
        chkv(dout[52 -: 12], 12'hA5C);
        chk1(bsy[37], 1'h1);
        chkv({4'h0, dout[36 -: 8]}, 12'h0A5);
        chk1(dout[28], 1'h0);
        chk1(pdv[30], 1'h1);
        chk1(pdv[25], 1'h0);
        chkv({9'h0, muxChannel}, 12'h002);
        chk1(refPowered, 1'h1);
        chk1(adcPowered, 1'h1);
        chk1(serialOutOe, 1'h1);
        chk1(busyOe, 1'h1);
    endtask : t_overlap16
    // two 12-bit conversions 15 clocks apart, auto power-down
    task automatic t_fast15();
        @(negedge sys_clk) adcCode = 12'h801;
        host.stream({mk(3'h1, 1'h0, 1'h0, 1'h0, 1'h0), 7'h0,
                     mk(3'h3, 1'h0, 1'h0, 1'h0, 1'h0), 41'h0}, 37, dout, bsy);
        chkv(dout[54 -: 12], 12'h801);
        chk1(bsy[40], 1'h1);
        chkv(dout[39 -: 12], 12'h801);
        chk1(pdv[21], 1'h1);
        chk1(refPowered, 1'h0);
        chk1(adcPowered, 1'h0);
        repeat (6) @(negedge sys_clk);
        chk1(sysAdcPowered, 1'h0);
        chk1(sysRefPowered, 1'h0);
    endtask : t_fast15
    // stall mid-conversion, then deselect
    task automatic t_abort();
        host.stream({mk(3'h4, 1'h0, 1'h1, 1'h1, 1'h0), 56'h0}, 12, dout, bsy);
        chk1(bsy[55], 1'h1);
        chk1(adcPowered, 1'h1);
        chk1(droopWarn, 1'h0);
        repeat (250) @(negedge sys_clk);
        chk1(droopWarn, 1'h1);
        chk1(refPowered, 1'h1);
        host.select(1'h1);
        chk1(serialOutOe, 1'h0);
        chk1(busyOe, 1'h0);
        chk1(adcPowered, 1'h0);
        chk1(refPowered, 1'h1);
        host.select(1'h0);
        host.stream(64'h0, 10, dout, bsy);
        chk1(|dout, 1'h0);
        chk1(|bsy, 1'h0);
        host.select(1'h1);
    endtask : t_abort

    // ==========================================================
    // main sequence and watchdog
    initial begin
        nrst    = 1'h0;
        adcCode = 12'h000;
        fork
            repeat (5) @(negedge sys_clk);
            host.stream(64'h0, 1, dout, bsy);
        join
        @(negedge sys_clk) nrst = 1'h1;
        // deselect after power-up, then check the idle outputs
        host.select(1'h1);
        t_reset();
        t_overlap16();
        t_fast15();
        t_abort();
        close_out();
    end
    initial begin
        #100000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
endmodule : test_touch_adc_serial_conversion_control
`default_nettype wire
